// *** urlef_core.sv ***
// receive side of a serial port with its line status error flags
// assumes the serial input is asynchronous and a single-cycle register port
// How it works
// (R1) reading line status clears break, and without FIFO break shows at once and holds until that read
// (R2) a character with a low stop bit raises the framing error flag in bit 3
// (R3) with FIFO on, the framing error rides with its character and shows when it reaches the head
// (R4) after a framing error other than a break the low stop sample is taken as the next start bit and reception continues
// (R5) a break also sets the framing error flag beside the break flag
// (R6) a parity mismatch sets bit 2 only while parity enable, bit 3 of line control, is set
// (R7) with FIFO on, the parity error rides with its character and shows when it reaches the head
// (R8) a break also sets the parity error flag
// (R9) reading line status clears the parity error flag, which resets to zero
// (R10) reading line status clears the framing error flag, which resets to zero
// (R11) without FIFO a character arriving over an unread one sets overrun and replaces it
// (R12) with FIFO on and full, a new character sets overrun and is dropped, the FIFO untouched
// (R13) reading line status clears the overrun flag, which resets to zero
// (R14) a line low for more than a whole frame is a break, giving exactly one all-zero character
// (R15) FIFO mode is in effect only while bit 0 of fifo control is one
// (R16) a status read returns the flags as they were and clears them, and a new event in that cycle wins
`timescale 1ns/10ps
module urlef_core #(
	parameter int unsigned FIFO_AW = 4
) (
	input  wire logic                        sys_clk_in,
	input  wire logic                        rstn_in,
	input  wire logic                        serial_in,
	input  wire logic [urlef_pkg::REG_AW-1:0] reg_addr_in,
	input  wire logic [urlef_pkg::REG_DW-1:0] reg_wdata_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	output logic      [urlef_pkg::REG_DW-1:0] reg_rdata_out,
	output logic                             irq_out
);
	localparam int unsigned EW = urlef_pkg::ENTRY_W;
	localparam int unsigned LW = urlef_pkg::LS_W;

	// input synchroniser
	logic rx_meta_r;
	logic rx_s_r;

	// software registers
	logic [7:0]    line_ctrl_r;
	logic [7:0]    fifo_ctrl_r;
	logic [15:0]   divisor_r;
	logic [LW-1:0] int_status_r;
	logic [LW-1:0] int_mask_r;

	// sticky error flags of line status
	logic oe_r;
	logic pe_r;
	logic fe_r;
	logic bi_r;

	// receiver
	urlef_pkg::urlef_state_t state_r;
	urlef_pkg::urlef_state_t state_nxt;
	logic [15:0] div_cnt_r;
	logic [3:0]  os_cnt_r;
	logic [3:0]  os_cnt_nxt;
	logic [2:0]  bit_idx_r;
	logic [2:0]  bit_idx_nxt;
	logic [7:0]  shift_r;
	logic        par_bit_r;

	// single buffer
	logic [EW-1:0] hold_r;
	logic          hold_valid_r;

	// fifo control
	logic [FIFO_AW:0] wr_ptr_r;
	logic [FIFO_AW:0] rd_ptr_r;
	logic             stale_r;
	logic [EW-1:0]    byp_r;
	logic             head_seen_r;

	urlef_mem_if #(.AW(FIFO_AW), .DW(EW)) mem_bus ();

	urlef_fifo_mem #(
		.AW (FIFO_AW),
		.DW (EW)
	) u_mem (
		.sys_clk_in (sys_clk_in),
		.port       (mem_bus.mem)
	);

	// ---- register decode ----
	wire sel_ls   = reg_addr_in == urlef_pkg::OFF_LINE_STATUS;
	wire sel_rb   = reg_addr_in == urlef_pkg::OFF_RX_BUFFER;
	wire sel_lc   = reg_addr_in == urlef_pkg::OFF_LINE_CTRL;
	wire sel_fc   = reg_addr_in == urlef_pkg::OFF_FIFO_CTRL;
	wire sel_dv   = reg_addr_in == urlef_pkg::OFF_DIVISOR;
	wire sel_is   = reg_addr_in == urlef_pkg::OFF_INT_STATUS;
	wire sel_im   = reg_addr_in == urlef_pkg::OFF_INT_MASK;
	wire ls_read  = reg_rd_in && sel_ls;
	wire rb_read  = reg_rd_in && sel_rb;

	wire fifo_en  = fifo_ctrl_r[urlef_pkg::FC_EN]; // R15
	wire parity_enable      = line_ctrl_r[urlef_pkg::LC_PEN];
	wire even_par = line_ctrl_r[urlef_pkg::LC_EVEN];
	wire [2:0] last_idx = {1'b0, line_ctrl_r[urlef_pkg::LC_WLEN_LO +: 2]} + urlef_pkg::WLEN_BASE;

	// ---- baud tick and sampling ----
	wire tick      = (div_cnt_r + 16'h0001) >= divisor_r;
	wire samp_mid  = tick && (os_cnt_r == urlef_pkg::OS_MID);
	wire samp_last = tick && (os_cnt_r == urlef_pkg::OS_LAST);

	// ---- frame end evaluation ----
	wire frame_done = (state_r == urlef_pkg::ST_STOP) && samp_last;
	wire stop_bad   = !rx_s_r;                                           // R2
	wire par_xor    = (^shift_r) ^ par_bit_r;
	wire par_bad    = parity_enable && (even_par ? par_xor : !par_xor);           // R6
	wire line_zero  = (shift_r == 8'h00) && !(parity_enable && par_bit_r);
	wire brk_now    = stop_bad && line_zero;                            // R14
	wire fe_now     = stop_bad;                                         // R5
	wire pe_now     = par_bad || brk_now;                               // R8
	wire [EW-1:0] new_entry = {brk_now, fe_now, pe_now, brk_now ? 8'h00 : shift_r};

	// ---- fifo bookkeeping ----
	wire fifo_empty = wr_ptr_r == rd_ptr_r;
	wire fifo_full  = (wr_ptr_r[FIFO_AW] != rd_ptr_r[FIFO_AW]) &&
	                  (wr_ptr_r[FIFO_AW-1:0] == rd_ptr_r[FIFO_AW-1:0]);
	wire push       = fifo_en && frame_done && !fifo_full;               // R12
	wire pop        = fifo_en && rb_read && !fifo_empty;
	// read one ahead so back to back buffer reads never see the popped entry
	wire [FIFO_AW:0] rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
	// a write into the slot about to be head misses the registered read
	wire new_head   = push && (wr_ptr_r == rd_ptr_nxt);
	wire head_entry = fifo_en && !fifo_empty && !head_seen_r;
	wire [EW-1:0] head = stale_r ? byp_r : mem_bus.rd_data;

	assign mem_bus.wr_en   = push;
	assign mem_bus.wr_addr = wr_ptr_r[FIFO_AW-1:0];
	assign mem_bus.wr_data = new_entry;
	assign mem_bus.rd_addr = rd_ptr_nxt[FIFO_AW-1:0];

	// ---- flag set events ----
	wire ovr_single = !fifo_en && frame_done && hold_valid_r && !rb_read; // R11
	wire ovr_fifo   = fifo_en && frame_done && fifo_full;                 // R12
	wire set_oe     = ovr_single || ovr_fifo;
	wire set_pe     = fifo_en ? (head_entry && head[urlef_pkg::E_PE])
	                          : (frame_done && pe_now);                   // R7
	wire set_fe     = fifo_en ? (head_entry && head[urlef_pkg::E_FE])
	                          : (frame_done && fe_now);                   // R3
	wire set_bi     = fifo_en ? (head_entry && head[urlef_pkg::E_BI])
	                          : (frame_done && brk_now);                  // R1
	wire data_ready = fifo_en ? !fifo_empty : hold_valid_r;

	wire [LW-1:0] line_status = {bi_r, fe_r, pe_r, oe_r, data_ready};
	wire [LW-1:0] int_events  = {set_bi, set_fe, set_pe, set_oe, frame_done};
	wire [LW-1:0] int_clear   = (reg_wr_in && sel_is) ? reg_wdata_in[LW-1:0] : {LW{1'b0}};
	wire [LW-1:0] int_status_nxt = (int_status_r & ~int_clear) | int_events;
	wire          irq_nxt     = |(int_status_r & int_mask_r);

	// ---- read data mux ----
	wire [7:0] rx_byte = fifo_en ? head[7:0] : hold_r[7:0];
	wire [urlef_pkg::REG_DW-1:0] rdata_nxt =
		!reg_rd_in ? {urlef_pkg::REG_DW{1'b0}} :
		sel_ls     ? {{(urlef_pkg::REG_DW-LW){1'b0}}, line_status} :   // R16
		sel_rb     ? {8'h00, rx_byte} :
		sel_lc     ? {8'h00, line_ctrl_r} :
		sel_fc     ? {8'h00, fifo_ctrl_r} :
		sel_dv     ? divisor_r :
		sel_is     ? {{(urlef_pkg::REG_DW-LW){1'b0}}, int_status_r} :
		sel_im     ? {{(urlef_pkg::REG_DW-LW){1'b0}}, int_mask_r} :
		{urlef_pkg::REG_DW{1'b0}};

	// ---- receiver next state ----
	always_comb begin
		state_nxt   = state_r;
		os_cnt_nxt  = tick ? os_cnt_r + 4'h1 : os_cnt_r;
		bit_idx_nxt = bit_idx_r;
		case (state_r)
			urlef_pkg::ST_IDLE: begin
				os_cnt_nxt = 4'h0;
				if (!rx_s_r) begin
					state_nxt = urlef_pkg::ST_START;
				end
			end
			urlef_pkg::ST_START: begin
				// a glitch shorter than half a bit is not a start
				if (samp_mid) begin
					os_cnt_nxt  = 4'h0;
					bit_idx_nxt = 3'h0;
					state_nxt   = rx_s_r ? urlef_pkg::ST_IDLE : urlef_pkg::ST_DATA;
				end
			end
			urlef_pkg::ST_DATA: begin
				if (samp_last) begin
					bit_idx_nxt = bit_idx_r + 3'h1;
					if (bit_idx_r == last_idx) begin
						state_nxt = parity_enable ? urlef_pkg::ST_PARITY : urlef_pkg::ST_STOP;
					end
				end
			end
			urlef_pkg::ST_PARITY: begin
				if (samp_last) begin
					state_nxt = urlef_pkg::ST_STOP;
				end
			end
			urlef_pkg::ST_STOP: begin
				if (samp_last) begin
					bit_idx_nxt = 3'h0;
					if (brk_now) begin
						state_nxt = urlef_pkg::ST_BRK_WAIT;    // R14
					end else if (stop_bad) begin
						state_nxt = urlef_pkg::ST_DATA;        // R4
					end else begin
						state_nxt = urlef_pkg::ST_IDLE;
					end
				end
			end
			urlef_pkg::ST_BRK_WAIT: begin
				// one character per break: wait for the line to go idle
				os_cnt_nxt = 4'h0;
				if (rx_s_r) begin
					state_nxt = urlef_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = urlef_pkg::ST_IDLE;
			end
		endcase
	end

	// ---- sequential logic ----
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_meta_r <= 1'b1;
			rx_s_r    <= 1'b1;
		end else begin
			rx_meta_r <= serial_in;
			rx_s_r    <= rx_meta_r;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_cnt_r <= 16'h0000;
			state_r   <= urlef_pkg::ST_IDLE;
			os_cnt_r  <= 4'h0;
			bit_idx_r <= 3'h0;
		end else begin
			div_cnt_r <= tick ? 16'h0000 : div_cnt_r + 16'h0001;
			state_r   <= state_nxt;
			os_cnt_r  <= os_cnt_nxt;
			bit_idx_r <= bit_idx_nxt;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			shift_r   <= 8'h00;
			par_bit_r <= 1'b0;
		end else if (state_r == urlef_pkg::ST_START && samp_mid) begin
			shift_r   <= 8'h00;
			par_bit_r <= 1'b0;
		end else if (state_r == urlef_pkg::ST_STOP && samp_last) begin
			shift_r   <= 8'h00;                            // R4
			par_bit_r <= 1'b0;
		end else if (state_r == urlef_pkg::ST_DATA && samp_last) begin
			shift_r[bit_idx_r] <= rx_s_r;
		end else if (state_r == urlef_pkg::ST_PARITY && samp_last) begin
			par_bit_r <= rx_s_r;
		end
	end

	// single buffer: a new character always replaces the held one
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hold_r       <= {EW{1'b0}};
			hold_valid_r <= 1'b0;
		end else if (!fifo_en && frame_done) begin
			hold_r       <= new_entry;                     // R11
			hold_valid_r <= 1'b1;
		end else if (!fifo_en && rb_read) begin
			hold_valid_r <= 1'b0;
		end
	end

	// leaving or entering fifo mode flushes the fifo
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_r    <= '0;
			rd_ptr_r    <= '0;
			stale_r     <= 1'b0;
			byp_r       <= {EW{1'b0}};
			head_seen_r <= 1'b0;
		end else if (!fifo_en) begin
			wr_ptr_r    <= '0;
			rd_ptr_r    <= '0;
			stale_r     <= 1'b0;
			byp_r       <= {EW{1'b0}};
			head_seen_r <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_nxt;
			end
			// for one cycle the fresh head comes from the bypass copy
			if (new_head) begin
				byp_r <= new_entry;
			end
			stale_r     <= new_head;
			head_seen_r <= pop ? 1'b0 : (head_seen_r || head_entry);
		end
	end

	// sticky flags: set beats the clear of a status read
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			oe_r <= 1'b0;
			pe_r <= 1'b0;
			fe_r <= 1'b0;
			bi_r <= 1'b0;
		end else begin
			oe_r <= set_oe || (oe_r && !ls_read);              // R13 R16
			pe_r <= set_pe || (pe_r && !ls_read);              // R9
			fe_r <= set_fe || (fe_r && !ls_read);              // R10
			bi_r <= set_bi || (bi_r && !ls_read);              // R1
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			line_ctrl_r <= urlef_pkg::LINE_CTRL_RST;
			fifo_ctrl_r <= urlef_pkg::FIFO_CTRL_RST;
			divisor_r   <= urlef_pkg::DIVISOR_RST;
			int_mask_r  <= urlef_pkg::INT_MASK_RST;
		end else if (reg_wr_in) begin
			if (sel_lc) begin
				line_ctrl_r <= reg_wdata_in[7:0];
			end
			if (sel_fc) begin
				fifo_ctrl_r <= reg_wdata_in[7:0];
			end
			if (sel_dv) begin
				divisor_r <= reg_wdata_in;
			end
			if (sel_im) begin
				int_mask_r <= reg_wdata_in[LW-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			int_status_r  <= {LW{1'b0}};
			irq_out       <= 1'b0;
			reg_rdata_out <= {urlef_pkg::REG_DW{1'b0}};
		end else begin
			int_status_r  <= int_status_nxt;
			irq_out       <= irq_nxt;
			reg_rdata_out <= rdata_nxt;
		end
	end

endmodule

// *** urlef_core_properties.sv ***
// concurrent checks on the ports of the receive line-error block
// assumes the bench runs the oversample divisor at 1
`timescale 1ns/10ps
module urlef_core_properties (
	input wire logic        sys_clk_in,
	input wire logic        rstn_in,
	input wire logic        serial_in,
	input wire logic [4:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        irq_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	// a frame can still end this long after the line went high
	localparam int QUIET = 240;
	logic [8:0] quiet_r;
	logic [3:0] pop_gap_r;
	logic [7:0] wd_r;
	wire ls_rd  = reg_rd_in && reg_addr_in == urlef_pkg::OFF_LINE_STATUS;
	wire buf_rd = reg_rd_in && reg_addr_in == urlef_pkg::OFF_RX_BUFFER;
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			quiet_r <= 9'h000;
			pop_gap_r <= 4'h0;
			wd_r <= 8'h00;
		end else begin
			quiet_r <= !serial_in ? 9'h000 : (quiet_r == 9'h1FF ? quiet_r : quiet_r + 9'h001);
			pop_gap_r <= buf_rd ? 4'h0 : (pop_gap_r == 4'hF ? pop_gap_r : pop_gap_r + 4'h1);
			wd_r <= reg_wr_in ? reg_wdata_in[7:0] : wd_r;
		end
	end
	chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
		else $error("read data not zero outside answer cycle");
	chk_status_upper_zero: assert property (ls_rd |=> reg_rdata_out[15:5] == 11'h000)
		else $error("line status upper bits not zero");
	chk_break_has_fe: assert property (ls_rd ##1 reg_rdata_out[4] |-> reg_rdata_out[3])
		else $error("break without framing error");
	chk_break_has_pe: assert property (ls_rd ##1 reg_rdata_out[4] |-> reg_rdata_out[2])
		else $error("break without parity error");
	chk_read_clears_flags: assert property (ls_rd && $past(ls_rd) && quiet_r >= QUIET && pop_gap_r >= 4'h8 |=> reg_rdata_out[4:1] == 4'h0)
		else $error("status flags survived a status read");
	chk_fifo_ctrl_back: assert property (reg_wr_in && reg_addr_in == urlef_pkg::OFF_FIFO_CTRL ##1 reg_rd_in && reg_addr_in == urlef_pkg::OFF_FIFO_CTRL |=> reg_rdata_out == {8'h00, wd_r})
		else $error("fifo control readback wrong");
	chk_line_ctrl_back: assert property (reg_wr_in && reg_addr_in == urlef_pkg::OFF_LINE_CTRL ##1 reg_rd_in && reg_addr_in == urlef_pkg::OFF_LINE_CTRL |=> reg_rdata_out == {8'h00, wd_r})
		else $error("line control readback wrong");
	chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 5'h1C |=> reg_rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	chk_irq_masked_off: assert property (reg_wr_in && reg_addr_in == urlef_pkg::OFF_INT_MASK && reg_wdata_in[4:0] == 5'h00 |-> ##2 !irq_out)
		else $error("irq high with all sources masked");
endmodule
bind urlef_core urlef_core_properties u_props (
	.sys_clk_in(sys_clk_in),
	.rstn_in(rstn_in),
	.serial_in(serial_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.irq_out(irq_out)
);

// *** urlef_core_tb.sv ***
// self-checking bench of the receive line-error block
// assumes the partner transmitter and the property checker beside it
`timescale 1ns/10ps
module urlef_core_tb;
	localparam logic [4:0] LS = urlef_pkg::OFF_LINE_STATUS;
	localparam logic [4:0] RB = urlef_pkg::OFF_RX_BUFFER;
	localparam logic [4:0] LC = urlef_pkg::OFF_LINE_CTRL;
	localparam logic [4:0] FC = urlef_pkg::OFF_FIFO_CTRL;
	localparam logic [4:0] IS = urlef_pkg::OFF_INT_STATUS;
	localparam logic [4:0] IM = urlef_pkg::OFF_INT_MASK;
	logic        sys_clk_in;
	logic        rstn_in;
	logic        serial_in;
	logic [4:0]  reg_addr_in;
	logic [15:0] reg_wdata_in;
	logic        reg_wr_in;
	logic        reg_rd_in;
	logic [15:0] reg_rdata_out;
	logic        irq_out;
	int          errors;
	int          total_checks;
	urlef_core #(.FIFO_AW(4)) u_dut (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.serial_in(serial_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.irq_out(irq_out)
	);
	urlef_tx_model u_tx (.clk_in(sys_clk_in), .line_out(serial_in));
	initial begin
		sys_clk_in = 1'h0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	task automatic finish_test();
		if (errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// both bus tasks start right after an edge
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_wr_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'h0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		reg_rd_in <= 1'h1;
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'h0;
		#1 chk($sformatf("reg_%h", a), e, reg_rdata_out);
	endtask
	task automatic cfg(input logic [4:0] a, input logic [15:0] v);
		wr(a, v);
		rdc(a, v);
	endtask
	// polling status would clear flags, so poll the interrupt status instead
	task automatic wait_char();
		for (int i = 0; i < 400; i++) begin
			reg_rd_in <= 1'h1;
			reg_addr_in <= IS;
			@(posedge sys_clk_in);
			reg_rd_in <= 1'h0;
			#1;
			if (reg_rdata_out[0] === 1'h1) begin
				wr(IS, 16'h0001);
				#1;
				return;
			end
		end
		errors++;
		finish_test();
	endtask
	task automatic t_reset();
		rdc(LS, 16'h0000);
		rdc(LC, 16'h0003);
		rdc(FC, 16'h0000);
		rdc(urlef_pkg::OFF_DIVISOR, 16'h000B);
		rdc(IM, 16'h0000);
		rdc(IS, 16'h0000);
		rdc(5'h1C, 16'h0000);
		cfg(urlef_pkg::OFF_DIVISOR, 16'h0001);
	endtask
	// low stop: framing error, then the resync frame overruns the buffer
	task automatic t_frame();
		cfg(IM, 16'h0008);
		u_tx.send(8'h5A, 1'h0, 1'h0, 1'h0, 1'h0);
		wait_char();
		chk("irq_fe", 16'h0001, {15'h0000, irq_out});
		wr(IS, 16'h0008);
		repeat (2) @(posedge sys_clk_in);
		#1 chk("irq_clr", 16'h0000, {15'h0000, irq_out});
		wait_char();
		rdc(LS, 16'h000B);
		rdc(LS, 16'h0001);
		rdc(RB, 16'h00FF);
		cfg(IM, 16'h0000);
	endtask
	task automatic par(input logic [15:0] lc, input logic flip, input logic [15:0] e);
		cfg(LC, lc);
		u_tx.send(8'h33, lc[3], lc[4], flip, 1'h1);
		wait_char();
		rdc(LS, e);
		rdc(RB, 16'h0033);
	endtask
	task automatic t_parity();
		par(16'h001B, 1'h1, 16'h0005);
		par(16'h001B, 1'h0, 16'h0001);
		par(16'h000B, 1'h1, 16'h0005);
		par(16'h000B, 1'h0, 16'h0001);
		par(16'h0003, 1'h1, 16'h0001);
	endtask
	task automatic t_break();
		wr(IS, 16'h001F);
		u_tx.level(1'h0, 12);
		wait_char();
		rdc(LS, 16'h001D);
		rdc(RB, 16'h0000);
		u_tx.level(1'h1, 12);
		repeat (250) @(posedge sys_clk_in);
		rdc(IS, 16'h001C);
		rdc(LS, 16'h0000);
		rdc(LS, 16'h0000);
	endtask
	// fill to full with a bad-parity second entry, then overrun and drain
	task automatic t_fifo();
		cfg(FC, 16'h0001);
		cfg(LC, 16'h001B);
		for (int i = 0; i < 16; i++) begin
			u_tx.send(8'h10 + 8'(i), 1'h1, 1'h1, i == 1, 1'h1);
			wait_char();
		end
		rdc(LS, 16'h0001);
		u_tx.send(8'hEE, 1'h1, 1'h1, 1'h0, 1'h1);
		repeat (8) @(posedge sys_clk_in);
		rdc(LS, 16'h0003);
		rdc(RB, 16'h0010);
		repeat (4) @(posedge sys_clk_in);
		rdc(LS, 16'h0005);
		for (int i = 1; i < 16; i++) rdc(RB, 16'h0010 + 16'(i));
		rdc(LS, 16'h0000);
		wr(IS, 16'h001F);
		u_tx.level(1'h0, 14);
		u_tx.level(1'h1, 2);
		wait_char();
		rdc(LS, 16'h001D);
		rdc(RB, 16'h0000);
		cfg(FC, 16'h0000);
	endtask
	initial begin
		errors = 0;
		total_checks = 0;
		rstn_in = 1'h0;
		reg_addr_in = 5'h00;
		reg_wdata_in = 16'h0000;
		reg_wr_in = 1'h0;
		reg_rd_in = 1'h0;
		repeat (4) @(posedge sys_clk_in);
		rstn_in <= 1'h1;
		@(posedge sys_clk_in);
		t_reset();
		t_frame();
		t_parity();
		t_break();
		t_fifo();
		finish_test();
	end
endmodule

// *** urlef_fifo_mem.sv ***
// entry memory of the receive FIFO: one write port, registered read
// assumes the controller keeps its own pointers and counts
`timescale 1ns/10ps
module urlef_fifo_mem #(
	parameter int unsigned AW = 4,
	parameter int unsigned DW = 11
) (
	input  wire logic sys_clk_in,
	urlef_mem_if.mem  port
);
	logic [DW-1:0] mem_r [0:(1<<AW)-1];
	logic [DW-1:0] rd_data_r;

	// no reset on the array: contents are only read behind valid pointers
	always_ff @(posedge sys_clk_in) begin
		if (port.wr_en) begin
			mem_r[port.wr_addr] <= port.wr_data;
		end
		rd_data_r <= mem_r[port.rd_addr];
	end

	assign port.rd_data = rd_data_r;
endmodule

// *** urlef_mem_if.sv ***
// signals between the receive logic and its entry memory
// assumes one clock domain; the memory registers its read data
`timescale 1ns/10ps
interface urlef_mem_if #(
	parameter int unsigned AW = 4,
	parameter int unsigned DW = 11
);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** urlef_pkg.sv ***
// constants and types shared by the receive line-error block, its property checker and its bench
// assumes a 16-bit register port and a 16x oversampled receiver
package urlef_pkg;

	localparam int unsigned REG_AW = 5;
	localparam int unsigned REG_DW = 16;
	localparam int unsigned ENTRY_W = 11;

	localparam logic [REG_AW-1:0] OFF_LINE_STATUS = 5'h00;
	localparam logic [REG_AW-1:0] OFF_RX_BUFFER   = 5'h04;
	localparam logic [REG_AW-1:0] OFF_LINE_CTRL   = 5'h08;
	localparam logic [REG_AW-1:0] OFF_FIFO_CTRL   = 5'h0C;
	localparam logic [REG_AW-1:0] OFF_DIVISOR     = 5'h10;
	localparam logic [REG_AW-1:0] OFF_INT_STATUS  = 5'h14;
	localparam logic [REG_AW-1:0] OFF_INT_MASK    = 5'h18;

	// line status and interrupt status share this layout
	localparam int unsigned LS_DR = 0;
	localparam int unsigned LS_OE = 1;
	localparam int unsigned LS_PE = 2;
	localparam int unsigned LS_FE = 3;
	localparam int unsigned LS_BI = 4;
	localparam int unsigned LS_W  = 5;

	localparam int unsigned LC_WLEN_LO = 0;
	localparam int unsigned LC_PEN     = 3;
	localparam int unsigned LC_EVEN    = 4;
	localparam int unsigned FC_EN      = 0;

	// stored entry: {break, framing, parity, data[7:0]}
	localparam int unsigned E_PE = 8;
	localparam int unsigned E_FE = 9;
	localparam int unsigned E_BI = 10;

	localparam logic [7:0]      LINE_CTRL_RST = 8'h03;
	localparam logic [7:0]      FIFO_CTRL_RST = 8'h00;
	localparam logic [15:0]     DIVISOR_RST   = 16'h000B;
	localparam logic [LS_W-1:0] INT_MASK_RST  = 5'h00;

	localparam logic [3:0] OS_MID  = 4'h7;
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [2:0] WLEN_BASE = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_START    = 3'b001,
		ST_DATA     = 3'b010,
		ST_PARITY   = 3'b011,
		ST_STOP     = 3'b100,
		ST_BRK_WAIT = 3'b101
	} urlef_state_t;

endpackage

// *** urlef_tx_model.sv ***
// remote serial transmitter driving the receive line
// assumes 16 clocks per bit, i.e. divisor 1; line idles high
`timescale 1ns/10ps
module urlef_tx_model (
	input  wire logic clk_in,
	output logic      line_out
);
	initial line_out = 1'h1;
	task automatic level(input logic b, input int n);
		line_out <= b;
		repeat (n * 16) @(posedge clk_in);
	endtask
	// flip corrupts the parity bit, a low stop makes a framing error
	task automatic send(input logic [7:0] d, input logic parity_enable, input logic even, input logic flip, input logic stop);
		level(1'h0, 1);
		for (int i = 0; i < 8; i++) level(d[i], 1);
		if (parity_enable) level(^d ^ ~even ^ flip, 1);
		level(stop, 1);
		line_out <= 1'h1;
		@(posedge clk_in);
	endtask
endmodule
